// *** rdc_port_map.svh ***
// constants and rule overview for the resolver converter host data port
// Overview of operation
// - chip select low enables the read and write/frame-sync strobes; sample acts without it
// - read and write strobes act on edges; frame-sync acts on its level
// - parallel bus driven only while select, read low
// - parallel byte accepted while select, write low
// - frame-sync with select frames each serial transfer
// - serial output bit shifted on clock rising edge
// - serial input bit captured on clock falling edge
// - top data line doubles as serial output
// - interface select polarity is a parameter
// - sample falling edge freezes position and velocity
// - same edge freezes fault flags for readback
// - resolution select pair sets presented width
// - logic other than the serial link shifter runs from the master clock input
// - bit 13 line is serial clock input
// - only low byte lines are bidirectional in parallel mode
`ifndef RDC_PORT_MAP_SVH
`define RDC_PORT_MAP_SVH
`define RDC_DATA_BITS 16
`define RDC_FAULT_BITS 8
`define RDC_FRAME_BITS 24
`define RDC_RX_LAST 3'h7
`define RDC_TX_FIRST 5'h17
`define RDC_MODE_POSITION 2'h0
`define RDC_MODE_VELOCITY 2'h2
`define RDC_MODE_CONFIG 2'h3
`define RDC_RES_10 2'h0
`define RDC_RES_12 2'h1
`define RDC_RES_14 2'h2
`define RDC_RES_16 2'h3
`define RDC_MASK_10 16'hFFC0
`define RDC_MASK_12 16'hFFF0
`define RDC_MASK_14 16'hFFFC
`define RDC_MASK_16 16'hFFFF
`define RDC_WORD_RESET 16'h0000
`define RDC_BYTE_RESET 8'h00
`define RDC_FRAME_RESET 24'h000000
`define RDC_MCLK_MIN_KHZ 6144
`define RDC_MCLK_MAX_KHZ 10240
`endif

// *** rdc_port_pkg.sv ***
// types used by the host data port, not by its serial link
`default_nettype none
package rdc_port_pkg;
   // host pins after synchronisation
   typedef struct packed {
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic port_sel;
      logic sample_n;
      logic mode_hi;
      logic mode_lo;
      logic res_hi;
      logic res_lo;
      logic [7:0] low_byte;
   } host_pins_t;

   // frozen converter results
   typedef struct packed {
      logic [15:0] position;
      logic [15:0] velocity;
      logic [7:0] fault;
   } snapshot_t;

   // parallel transfer state, one-hot
   typedef enum logic [2:0] {
      PORT_IDLE = 3'h1,
      PORT_READ = 3'h2,
      PORT_WRITE = 3'h4
   } port_state_t;
endpackage
`default_nettype wire

// *** rdc_serial_link.sv ***
// serial link shifter clocked by the host serial clock
`timescale 1ns/1ns
`default_nettype none
`include "rdc_port_map.svh"
module rdc_serial_link
(
   // link clock and resets
   input wire logic serial_clk,
   input wire logic link_rst_n,
   input wire logic frame_n,
   // data from and to the host pins
   input wire logic serial_in,
   output logic serial_out,
   // word to send, held stable by the system side during a frame
   input wire logic [`RDC_FRAME_BITS-1:0] tx_word,
   // received byte, toggle marks each new byte
   output logic [7:0] rx_byte,
   output logic rx_toggle
);
   logic [4:0] tx_index;
   logic [2:0] rx_count;
   logic [6:0] rx_shift;
   wire tx_done = (tx_index == 5'h00);
   wire rx_full = (rx_count == `RDC_RX_LAST);

   // the frame's own signal ends the transfer, so no edge after it is needed
   always_ff @(posedge serial_clk or posedge frame_n)
   begin
      if (frame_n)
      begin
         tx_index <= `RDC_TX_FIRST;
         serial_out <= 1'b0;
      end
      else
      begin
         serial_out <= tx_word[tx_index];
         tx_index <= tx_done ? tx_index : tx_index - 5'h01;
      end
   end

   always_ff @(negedge serial_clk or posedge frame_n)
   begin
      if (frame_n)
      begin
         rx_count <= 3'h0;
         rx_shift <= 7'h00;
      end
      else
      begin
         rx_shift <= {rx_shift[5:0], serial_in};
         rx_count <= rx_count + 3'h1;
      end
   end

   // byte and toggle survive the frame end so the system side never loses one
   always_ff @(negedge serial_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         rx_byte <= `RDC_BYTE_RESET;
         rx_toggle <= 1'b0;
      end
      else if (!frame_n && rx_full)
      begin
         rx_byte <= {rx_shift, serial_in};
         rx_toggle <= ~rx_toggle;
      end
   end
endmodule
`default_nettype wire

// *** rdc_host_data_port.sv ***
// host data port: parallel and serial access to converter results
`timescale 1ns/1ns
`default_nettype none
`include "rdc_port_map.svh"
module rdc_host_data_port
#(
   parameter bit SERIAL_WHEN_HIGH = 1'b1,
   parameter int MASTER_CLK_KHZ = 8192
)
(
   // master clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // host strobes and selects
   input wire logic chip_select_n,
   input wire logic read_n,
   input wire logic write_frame_sync_n,
   input wire logic port_type_select,
   input wire logic sample_n,
   input wire logic mode_sel_hi,
   input wire logic mode_sel_lo,
   input wire logic resolution_sel_hi,
   input wire logic resolution_sel_lo,
   // low byte lines, bidirectional
   input wire logic [7:0] data_low_byte,
   output logic [7:0] data_low_byte_out,
   output logic data_low_byte_oe,
   // upper lines, bits 8 to 14, three-state outputs
   output logic [14:8] data_high_out,
   output logic [14:8] data_high_oe,
   // bit 15, parallel data or serial output
   output logic data_msb_or_serial_out,
   output logic data_msb_or_serial_out_oe,
   // serial input and serial clock on lines 14 and 13
   input wire logic data_b14_or_serial_in,
   input wire logic data_b13_or_serial_clock,
   // converter core
   input wire logic [15:0] position_integrator,
   input wire logic [15:0] velocity_integrator,
   input wire logic [7:0] fault_flags,
   input wire logic [7:0] config_read_byte,
   output logic [1:0] resolution_setting,
   output logic config_write_valid,
   output logic [7:0] config_write_byte,
   output logic snapshot_taken
);
   // master clock band checked at elaboration
   if (MASTER_CLK_KHZ < `RDC_MCLK_MIN_KHZ || MASTER_CLK_KHZ > `RDC_MCLK_MAX_KHZ)
   begin
      $error("master clock outside the supported band");
   end

   function automatic logic [15:0] resolution_mask(input logic [1:0] res);
      logic [15:0] m;
      m = `RDC_MASK_16;
      case (res)
         `RDC_RES_10: m = `RDC_MASK_10;
         `RDC_RES_12: m = `RDC_MASK_12;
         `RDC_RES_14: m = `RDC_MASK_14;
         default: m = `RDC_MASK_16;
      endcase
      return m;
   endfunction

   function automatic logic [15:0] select_word(input logic [1:0] mode, input rdc_port_pkg::snapshot_t snap,
                                               input logic [7:0] cfg, input logic [1:0] res);
      logic [15:0] w;
      w = `RDC_WORD_RESET;
      case (mode)
         `RDC_MODE_POSITION: w = snap.position & resolution_mask(res);
         `RDC_MODE_VELOCITY: w = snap.velocity & resolution_mask(res);
         `RDC_MODE_CONFIG: w = {`RDC_BYTE_RESET, cfg};
         default: w = `RDC_WORD_RESET;
      endcase
      return w;
   endfunction

   // reset release through two flip-flops
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // pin synchronisers; stage one is read only by stage two
   rdc_port_pkg::host_pins_t pins_raw;
   rdc_port_pkg::host_pins_t pins_meta;
   rdc_port_pkg::host_pins_t pins;
   rdc_port_pkg::host_pins_t pins_prev;
   localparam rdc_port_pkg::host_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, port_sel: 1'b0,
      sample_n: 1'b1, mode_hi: 1'b0, mode_lo: 1'b0, res_hi: 1'b1, res_lo: 1'b1, low_byte: 8'h00};
   assign pins_raw = '{cs_n: chip_select_n, rd_n: read_n, wr_n: write_frame_sync_n,
      port_sel: port_type_select, sample_n: sample_n, mode_hi: mode_sel_hi, mode_lo: mode_sel_lo,
      res_hi: resolution_sel_hi, res_lo: resolution_sel_lo, low_byte: data_low_byte};

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pins_meta <= PINS_IDLE;
         pins <= PINS_IDLE;
         pins_prev <= PINS_IDLE;
      end
      else
      begin
         pins_meta <= pins_raw;
         pins <= pins_meta;
         pins_prev <= pins;
      end
   end

   // decode of synchronised pins
   wire serial_mode = (pins.port_sel == SERIAL_WHEN_HIGH);
   wire selected = ~pins.cs_n;
   wire [1:0] mode = {pins.mode_hi, pins.mode_lo};
   wire [1:0] res = {pins.res_hi, pins.res_lo};
   wire config_mode = (mode == `RDC_MODE_CONFIG);
   wire rd_fall = pins_prev.rd_n & ~pins.rd_n;
   wire rd_rise = ~pins_prev.rd_n & pins.rd_n;
   wire wr_fall = pins_prev.wr_n & ~pins.wr_n;
   wire wr_rise = ~pins_prev.wr_n & pins.wr_n;
   wire sample_fall = pins_prev.sample_n & ~pins.sample_n;
   wire par_selected = selected & ~serial_mode;
   wire frame_active = selected & serial_mode & ~pins.wr_n;

   // snapshot of the tracking loop on the sample falling edge
   rdc_port_pkg::snapshot_t snap;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         snap <= '{position: `RDC_WORD_RESET, velocity: `RDC_WORD_RESET, fault: `RDC_BYTE_RESET};
         snapshot_taken <= 1'b0;
      end
      else
      begin
         snapshot_taken <= sample_fall;
         if (sample_fall)
         begin
            snap.position <= position_integrator;
            snap.velocity <= velocity_integrator;
            snap.fault <= fault_flags;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         resolution_setting <= `RDC_RES_16;
      else
         resolution_setting <= res;
   end

   // parallel transfer state machine
   rdc_port_pkg::port_state_t state;
   rdc_port_pkg::port_state_t next_state;
   logic [15:0] read_word;
   logic [7:0] write_byte;
   wire [15:0] live_word = select_word(mode, snap, config_read_byte, res);
   wire write_commit = (state == rdc_port_pkg::PORT_WRITE) & wr_rise & selected;

   always_comb
   begin
      next_state = state;
      case (state)
         rdc_port_pkg::PORT_IDLE:
         begin
            if (par_selected && rd_fall)
               next_state = rdc_port_pkg::PORT_READ;
            else if (par_selected && wr_fall)
               next_state = rdc_port_pkg::PORT_WRITE;
         end
         rdc_port_pkg::PORT_READ:
         begin
            if (rd_rise || !par_selected)
               next_state = rdc_port_pkg::PORT_IDLE;
         end
         rdc_port_pkg::PORT_WRITE:
         begin
            if (wr_rise || !par_selected)
               next_state = rdc_port_pkg::PORT_IDLE;
         end
         default: next_state = rdc_port_pkg::PORT_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= rdc_port_pkg::PORT_IDLE;
         read_word <= `RDC_WORD_RESET;
         write_byte <= `RDC_BYTE_RESET;
      end
      else
      begin
         state <= next_state;
         if (state == rdc_port_pkg::PORT_IDLE && par_selected && rd_fall)
            read_word <= live_word;
         if (state == rdc_port_pkg::PORT_WRITE && !pins.wr_n)
            write_byte <= pins.low_byte;
      end
   end

   // serial word stays frozen while a frame runs, so the link reads it safely
   logic [`RDC_FRAME_BITS-1:0] tx_word;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         tx_word <= `RDC_FRAME_RESET;
      else if (!frame_active)
         tx_word <= {live_word, snap.fault};
   end

   // serial link on the host serial clock
   wire link_frame_n = chip_select_n | write_frame_sync_n | (port_type_select != SERIAL_WHEN_HIGH);
   logic serial_bit;
   logic [7:0] rx_byte;
   logic rx_toggle;

   rdc_serial_link link
   (
      .serial_clk(data_b13_or_serial_clock),
      .link_rst_n(rst_n),
      .frame_n(link_frame_n),
      .serial_in(data_b14_or_serial_in),
      .serial_out(serial_bit),
      .tx_word(tx_word),
      .rx_byte(rx_byte),
      .rx_toggle(rx_toggle)
   );

   // byte toggle crossing back to the system clock
   logic rx_tog_meta;
   logic rx_tog_sync;
   logic rx_tog_prev;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_tog_meta <= 1'b0;
         rx_tog_sync <= 1'b0;
         rx_tog_prev <= 1'b0;
      end
      else
      begin
         rx_tog_meta <= rx_toggle;
         rx_tog_sync <= rx_tog_meta;
         rx_tog_prev <= rx_tog_sync;
      end
   end
   wire rx_new = rx_tog_sync ^ rx_tog_prev;

   // configuration writes from either interface, only in configuration mode
   wire serial_write = rx_new & config_mode;
   wire parallel_write = write_commit & config_mode & ~serial_mode;
   wire [7:0] next_write_byte = serial_write ? rx_byte : write_byte;

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         config_write_valid <= 1'b0;
         config_write_byte <= `RDC_BYTE_RESET;
      end
      else
      begin
         config_write_valid <= serial_write | parallel_write;
         if (serial_write || parallel_write)
            config_write_byte <= next_write_byte;
      end
   end

   // pin drivers; enables use synchronised strobes, so the read enable rises three cycles after the pin and drops two after
   wire par_drive = (state == rdc_port_pkg::PORT_READ) & par_selected & ~pins.rd_n;
   assign data_low_byte_out = read_word[7:0];
   assign data_low_byte_oe = par_drive;
   assign data_high_out = read_word[14:8];
   assign data_high_oe = {7{par_drive}};
   assign data_msb_or_serial_out = serial_mode ? serial_bit : read_word[15];
   assign data_msb_or_serial_out_oe = serial_mode ? frame_active : par_drive;
endmodule
`default_nettype wire

// *** rdc_host_data_port_assertions.sv ***
// concurrent checks on the host data port pins
`timescale 1ns/1ns
`default_nettype none
module rdc_port_checker
(
   // watched ports
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic chip_select_n,
   input wire logic read_n,
   input wire logic write_frame_sync_n,
   input wire logic port_type_select,
   input wire logic sample_n,
   input wire logic resolution_sel_hi,
   input wire logic resolution_sel_lo,
   input wire logic data_low_byte_oe,
   input wire logic [14:8] data_high_oe,
   input wire logic data_msb_or_serial_out_oe,
   input wire logic [1:0] resolution_setting,
   input wire logic config_write_valid,
   input wire logic snapshot_taken
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // five cycles cover the two-flop synchroniser plus the state register
   select_gates_bus_a: assert property (chip_select_n [*5] |-> !data_low_byte_oe)
      else $error("bus driven while deselected");
   read_gates_bus_a: assert property (read_n [*5] |-> !data_low_byte_oe)
      else $error("bus driven without read");
   read_drives_bus_a: assert property ((!chip_select_n && !port_type_select && read_n) [*3]
      ##1 (!chip_select_n && !read_n) |-> ##[2:3] data_low_byte_oe)
      else $error("read not answered in time");
   upper_lines_follow_a: assert property (data_high_oe == {7{data_low_byte_oe}})
      else $error("upper enables differ from low byte enable");
   serial_out_floats_a: assert property ((port_type_select && (chip_select_n || write_frame_sync_n)) [*5]
      |-> !data_msb_or_serial_out_oe)
      else $error("serial output driven outside frame");
   serial_out_drives_a: assert property ((port_type_select && !chip_select_n && !write_frame_sync_n) [*4]
      |-> data_msb_or_serial_out_oe)
      else $error("serial output not driven in frame");
   sample_edge_snap_a: assert property ($fell(sample_n) |-> ##[2:4] snapshot_taken)
      else $error("sample edge not taken");
   snap_single_pulse_a: assert property (snapshot_taken |=> !snapshot_taken)
      else $error("snapshot pulse too long");
   write_single_pulse_a: assert property (config_write_valid |=> !config_write_valid)
      else $error("write pulse too long");
   resolution_follows_a: assert property ($stable({resolution_sel_hi, resolution_sel_lo}) [*4]
      |-> resolution_setting == {resolution_sel_hi, resolution_sel_lo})
      else $error("resolution setting not following selects");
   cover property (data_low_byte_oe);
   cover property (snapshot_taken);
   cover property (config_write_valid && port_type_select);
endmodule
bind rdc_host_data_port rdc_port_checker u_chk (.sys_clk, .reset_n, .chip_select_n, .read_n, .write_frame_sync_n,
   .port_type_select, .sample_n, .resolution_sel_hi, .resolution_sel_lo, .data_low_byte_oe, .data_high_oe,
   .data_msb_or_serial_out_oe, .resolution_setting, .config_write_valid, .snapshot_taken);
`default_nettype wire

// *** rdc_host_model.sv ***
// host side model of the serial clock and serial data lines
`timescale 1ns/1ns
`default_nettype none
module rdc_host_model
(
   // serial pins seen from the host
   output logic serial_clock,
   output logic serial_data,
   input wire logic serial_return
);
   initial
   begin
      serial_clock = 1'b0;
      serial_data = 1'b0;
   end
   // clock stands low between frames; input bit moves after the rise so it is steady at the fall
   // a configuration frame is one byte long, so only as many clocks as the frame needs are sent
   task automatic transfer(input logic [7:0] tx, input int nbits, output logic [23:0] rx);
      rx = 24'h000000;
      for (int i = 23; i > 23 - nbits; i--)
      begin
         #7 serial_clock = 1'b1;
         #1 serial_data = (i > 15) ? tx[i-16] : ~serial_data;
         #7 serial_clock = 1'b0;
         rx[i] = serial_return;
      end
   endtask
endmodule
`default_nettype wire

// *** rdc_host_data_port_bench.sv ***
// self-checking bench for the host data port
`timescale 1ns/1ns
`default_nettype none
module rdc_host_data_port_bench;
   logic sys_clk, reset_n, cs_n, rd_n, wr_n, sel, smp_n, m_hi, m_lo, r_hi, r_lo;
   logic low_oe, msb, msb_oe, sclk, sdi, wvalid, snap;
   logic [7:0] host_byte, low_out, wire_byte, fault, cfg_rd, wbyte;
   logic [14:8] high_out, high_oe;
   logic [15:0] pos, vel, word;
   logic [1:0] res_set;
   logic [23:0] frame;
   logic sdo_line;
   int n_fail, num_checks;
   assign wire_byte = low_oe ? low_out : host_byte;
   // an undriven line reads inverted, so a late or missing enable shows up as bad data
   assign sdo_line = msb_oe ? msb : ~msb;
   rdc_host_data_port i_dut (.sys_clk, .reset_n, .chip_select_n(cs_n), .read_n(rd_n), .write_frame_sync_n(wr_n),
      .port_type_select(sel), .sample_n(smp_n), .mode_sel_hi(m_hi), .mode_sel_lo(m_lo), .resolution_sel_hi(r_hi),
      .resolution_sel_lo(r_lo), .data_low_byte(wire_byte), .data_low_byte_out(low_out), .data_low_byte_oe(low_oe),
      .data_high_out(high_out), .data_high_oe(high_oe), .data_msb_or_serial_out(msb),
      .data_msb_or_serial_out_oe(msb_oe), .data_b14_or_serial_in(sdi), .data_b13_or_serial_clock(sclk),
      .position_integrator(pos), .velocity_integrator(vel), .fault_flags(fault), .config_read_byte(cfg_rd),
      .resolution_setting(res_set), .config_write_valid(wvalid), .config_write_byte(wbyte), .snapshot_taken(snap));
   rdc_host_model u_host (.serial_clock(sclk), .serial_data(sdi), .serial_return(sdo_line));
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_frame(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic host_read(input logic [1:0] mode, input logic en, output logic [15:0] w);
      @(negedge sys_clk);
      {m_hi, m_lo} = mode;
      cs_n = ~en;
      repeat (4) @(negedge sys_clk);
      rd_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      w = {(msb_oe ? msb : ~msb), (high_out ^ ~high_oe), (low_oe ? low_out : ~low_out)};
      chk_word({15'h0000, low_oe}, {15'h0000, en});
      rd_n = 1'b1;
      repeat (5) @(negedge sys_clk);
      cs_n = 1'b1;
   endtask
   // the pulse is caught at falling edges, where a one-cycle pulse is settled
   task automatic catch_write(input logic exp, input logic [7:0] b);
      logic seen;
      logic [7:0] got;
      seen = 1'b0;
      got = 8'h00;
      for (int i = 0; i < 60; i++)
      begin
         @(negedge sys_clk);
         if (wvalid === 1'b1)
         begin
            seen = 1'b1;
            got = wbyte;
         end
      end
      chk_word({15'h0000, seen}, {15'h0000, exp});
      if (exp) chk_word({8'h00, got}, {8'h00, b});
      if (exp && !seen) end_of_test();
   endtask
   task automatic host_write(input logic [1:0] mode, input logic [7:0] b, input logic exp);
      @(negedge sys_clk);
      {m_hi, m_lo} = mode;
      cs_n = 1'b0;
      host_byte = b;
      repeat (4) @(negedge sys_clk);
      wr_n = 1'b0;
      repeat (5) @(negedge sys_clk);
      wr_n = 1'b1;
      host_byte = ~b;
      catch_write(exp, b);
      cs_n = 1'b1;
   endtask
   initial
   begin
      n_fail = 0;
      num_checks = 0;
      reset_n = 1'b0;
      {cs_n, rd_n, wr_n, sel, smp_n, m_hi, m_lo, r_hi, r_lo} = 9'h1DB;
      host_byte = 8'h00;
      {pos, vel, fault, cfg_rd} = {16'hB6DB, 16'h4925, 8'h5A, 8'h3C};
      repeat (5) @(negedge sys_clk);
      reset_n = 1'b1;
      repeat (8) @(negedge sys_clk);
      smp_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      smp_n = 1'b1;
      repeat (4) @(negedge sys_clk);
      // integrators move after the snapshot; reads must still show the frozen values
      {pos, vel, fault} = 40'h0000000000;
      for (int r = 0; r < 4; r++)
      begin
         {r_hi, r_lo} = r[1:0];
         host_read(2'h0, 1'b1, word);
         chk_word(word, 16'hB6DB & (16'hFFFF << (6 - 2 * r)));
         host_read(2'h2, 1'b1, word);
         chk_word(word, 16'h4925 & (16'hFFFF << (6 - 2 * r)));
      end
      host_read(2'h3, 1'b1, word);
      chk_word(word, 16'h003C);
      host_read(2'h1, 1'b1, word);
      chk_word(word, 16'h0000);
      host_read(2'h0, 1'b0, word);
      $display("test parallel read done");
      host_write(2'h3, 8'hC3, 1'b1);
      host_write(2'h0, 8'h96, 1'b0);
      $display("test parallel write done");
      sel = 1'b1;
      {m_hi, m_lo} = 2'h0;
      repeat (4) @(negedge sys_clk);
      cs_n = 1'b0;
      wr_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk_word({15'h0000, msb_oe}, 16'h0001);
      u_host.transfer(8'h00, 24, frame);
      chk_frame(frame, {16'hB6DB, 8'h5A});
      wr_n = 1'b1;
      repeat (5) @(negedge sys_clk);
      chk_word({15'h0000, msb_oe}, 16'h0000);
      {m_hi, m_lo} = 2'h3;
      repeat (4) @(negedge sys_clk);
      wr_n = 1'b0;
      repeat (4) @(negedge sys_clk);
      fork
         u_host.transfer(8'h69, 8, frame);
         catch_write(1'b1, 8'h69);
      join
      wr_n = 1'b1;
      cs_n = 1'b1;
      repeat (5) @(negedge sys_clk);
      $display("test serial done");
      end_of_test();
   end
endmodule
`default_nettype wire
